/* File: hdl/pctl_map.vh */
// register offsets, field layouts and reset values of the port block
`ifndef PCTL_MAP_VH
`define PCTL_MAP_VH

// register word addresses on the plain register port
`define PCTL_ADDR_W 4
`define PCTL_OFS_DATA 4'h0
`define PCTL_OFS_DIR 4'h1
`define PCTL_OFS_OPT 4'h2
`define PCTL_OFS_SENS 4'h3
`define PCTL_OFS_ROUTE_LO 4'h4
`define PCTL_OFS_ROUTE_HI 4'h5
`define PCTL_OFS_PEND 4'h6
`define PCTL_OFS_ACK 4'h7
// upper sensitivity byte, vectors four to six
`define PCTL_OFS_SENS_HI 4'h8

// widths
`define PCTL_PINS 8
`define PCTL_VECS 7
`define PCTL_VEC_IDX_W 3

// reset values
`define PCTL_RST_BYTE 8'h00
`define PCTL_RST_ROUTE 16'h0000
`define PCTL_RST_SENS 14'h0000

// sensitivity field codes, two bits per vector
`define PCTL_SENS_FALL_LOW 2'h0
`define PCTL_SENS_RISE 2'h1
`define PCTL_SENS_FALL 2'h2
`define PCTL_SENS_BOTH 2'h3

// unassigned route code: pin feeds no vector
`define PCTL_ROUTE_NONE 2'h0

`endif

/* File: hdl/pctl_sync.v */
// two-stage synchroniser for the port pin levels
`timescale 1ns/10ps
module pctl_sync (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// asynchronous pin levels and their synchronised copies
	input wire [7:0] pin_async,
	output reg [7:0] pin_sync
);

	reg [7:0] meta;

	// first stage is read only by the second
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			meta <= 8'h00;
			pin_sync <= 8'h00;
		end else begin
			meta <= pin_async;
			pin_sync <= meta;
		end
	end

endmodule

/* File: hdl/pctl_edge.v */
// per-vector edge or level request detector with pending latch
`timescale 1ns/10ps
`include "pctl_map.vh"
module pctl_edge (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// combined interrupt source level and its sensitivity
	input wire src_level,
	input wire [1:0] sens,
	// clear requests
	input wire flush,
	input wire ack,
	// request latch
	output reg pending
);

	reg prev;
	wire rise;
	wire fall;
	wire hit;

	// compare current sample with previous one
	assign rise = src_level & ~prev;
	assign fall = ~src_level & prev;
	assign hit = (sens == `PCTL_SENS_RISE) ? rise :
		(sens == `PCTL_SENS_FALL) ? fall :
		(sens == `PCTL_SENS_BOTH) ? (rise | fall) : ~src_level;

	// a new event wins over an acknowledge or flush in the same cycle
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			prev <= 1'b1;
			pending <= 1'b0;
		end else begin
			prev <= src_level;
			if (hit)
				pending <= 1'b1;
			else if (flush || ack)
				pending <= 1'b0;
		end
	end

endmodule

/* File: hdl/pctl_port.v */
// general-purpose port: latch, direction, option, pin interrupts, alternates
// What this block does
// - eight pins, each input or output alone
// - data, direction, option bit x steers pin x only
// - direction zero: input, read returns pin level
// - input mode: data write updates latch only
// - input option bit selects pull-up over floating
// - input option bit enables pin interrupt
// - per-vector edge sensitivity in own register
// - seven vectors; shared pins combined logically
// - vector fetch clears pending request
// - sensitivity change discards all pending requests
// - direction one: drive latch, read latch
// - output option: push-pull or open-drain
// - enabled peripheral output overrides direction, data
// - under peripheral output, read returns pin
// - floating input feeds peripheral alternate input
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`include "pctl_map.vh"
module pctl_port (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// register port
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// processor vector fetch acknowledge
	input wire vec_fetch,
	input wire [2:0] vec_fetch_idx,
	// interrupt requests, one per vector
	output wire [6:0] ext_irq_req,
	// peripheral alternate functions
	input wire [7:0] alt_out_en,
	input wire [7:0] alt_out_val,
	output wire [7:0] alt_in,
	// pin pads, output enable low while driving
	input wire [7:0] pad_in,
	output wire [7:0] pad_out,
	output wire [7:0] pad_oe_n,
	output wire [7:0] pad_pullup
);

	reg [7:0] port_data_latch;
	reg [7:0] port_direction;
	reg [7:0] port_option;
	reg [13:0] ext_irq_sensitivity_control;
	reg [15:0] pin_vec_route;
	reg [7:0] next_rdata;
	reg [13:0] next_sens;
	wire [7:0] pin_level;
	wire [7:0] irq_en;
	wire [6:0] vec_level;
	wire [6:0] pending;
	wire sens_change;
	wire [6:0] ack_vec;
	wire [2:0] sw_ack_idx;
	wire sw_ack;
	wire [7:0] own_drive;

	// vector index for pins 0..7; two route bits pick one of three slots
	function [2:0] pctl_pin_vec;
		input [2:0] pin;
		input [1:0] route;
		begin
			if (route == `PCTL_ROUTE_NONE)
				pctl_pin_vec = 3'h7;
			else if (pin < 3'h4)
				pctl_pin_vec = {1'b0, route - 2'h1};
			else
				pctl_pin_vec = {1'b0, route - 2'h1} + 3'h3;
		end
	endfunction

	// one-hot decode of a vector index, seven wide
	function [6:0] pctl_vec_hot;
		input [2:0] idx;
		begin
			pctl_vec_hot = (idx < 3'h7) ? (7'h01 << idx) : 7'h00;
		end
	endfunction

	// pins pass two flip-flops before any logic sees them
	pctl_sync u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.pin_async(pad_in),
		.pin_sync(pin_level)
	);

	// sensitivity next value, used to spot a change on write
	always @* begin
		next_sens = ext_irq_sensitivity_control;
		if (reg_wr && reg_addr == `PCTL_OFS_SENS)
			next_sens = {ext_irq_sensitivity_control[13:8], reg_wdata};
		else if (reg_wr && reg_addr == `PCTL_OFS_SENS_HI)
			next_sens = {reg_wdata[5:0], ext_irq_sensitivity_control[7:0]};
	end

	assign sens_change = (next_sens != ext_irq_sensitivity_control);

	// register writes; reset leaves every pin a floating input
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			port_data_latch <= `PCTL_RST_BYTE;
			port_direction <= `PCTL_RST_BYTE;
			port_option <= `PCTL_RST_BYTE;
			ext_irq_sensitivity_control <= `PCTL_RST_SENS;
			pin_vec_route <= `PCTL_RST_ROUTE;
		end else begin
			ext_irq_sensitivity_control <= next_sens;
			if (reg_wr) begin
				case (reg_addr)
					`PCTL_OFS_DATA: port_data_latch <= reg_wdata;
					`PCTL_OFS_DIR: port_direction <= reg_wdata;
					`PCTL_OFS_OPT: port_option <= reg_wdata;
					`PCTL_OFS_ROUTE_LO: pin_vec_route[7:0] <= reg_wdata;
					`PCTL_OFS_ROUTE_HI: pin_vec_route[15:8] <= reg_wdata;
					default: ;
				endcase
			end
		end
	end

	// pin drivers: peripheral first, then the port's own setting
	genvar g;
	generate
		for (g = 0; g < `PCTL_PINS; g = g + 1) begin : g_pin
			// bit g of the data, direction and option registers steers pin g only
			assign own_drive[g] = port_direction[g] &
				(~port_option[g] | ~port_data_latch[g]);
			assign pad_out[g] = alt_out_en[g] ? alt_out_val[g] : port_data_latch[g];
			assign pad_oe_n[g] = ~(alt_out_en[g] | own_drive[g]);
			// pull-up only on an input with option set
			assign pad_pullup[g] = ~port_direction[g] & ~alt_out_en[g] & port_option[g];
			// interrupt only on an input with option set
			assign irq_en[g] = ~port_direction[g] & ~alt_out_en[g] & port_option[g];
		end
	endgenerate

	// the alternate input sees the synchronised pin level
	assign alt_in = pin_level;

	// combine enabled pins per vector with an and, so a low pin masks others
	genvar v;
	generate
		for (v = 0; v < `PCTL_VECS; v = v + 1) begin : g_vec
			wire [7:0] member;
			genvar p;
			for (p = 0; p < `PCTL_PINS; p = p + 1) begin : g_mem
				assign member[p] = irq_en[p] &
					(pctl_pin_vec(p, pin_vec_route[2*p +: 2]) == v);
			end
			// no member: idle high, never a request
			assign vec_level[v] = &(pin_level | ~member);
			pctl_edge u_edge (
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.src_level(vec_level[v]),
				.sens(ext_irq_sensitivity_control[2*v +: 2]),
				.flush(sens_change),
				.ack(ack_vec[v]),
				.pending(pending[v])
			);
		end
	endgenerate

	// fetch or a software acknowledge clears its latch
	assign sw_ack = reg_wr && (reg_addr == `PCTL_OFS_ACK);
	assign sw_ack_idx = reg_wdata[2:0];
	assign ack_vec = (vec_fetch ? pctl_vec_hot(vec_fetch_idx) : 7'h00) |
		(sw_ack ? pctl_vec_hot(sw_ack_idx) : 7'h00);
	assign ext_irq_req = pending;

	// read mux: pin level on inputs and under peripherals, latch on outputs
	always @* begin
		next_rdata = 8'h00;
		case (reg_addr)
			`PCTL_OFS_DATA: next_rdata = ((port_direction & ~alt_out_en) & port_data_latch) |
				(~(port_direction & ~alt_out_en) & pin_level);
			`PCTL_OFS_DIR: next_rdata = port_direction;
			`PCTL_OFS_OPT: next_rdata = port_option;
			`PCTL_OFS_SENS: next_rdata = ext_irq_sensitivity_control[7:0];
			`PCTL_OFS_ROUTE_LO: next_rdata = pin_vec_route[7:0];
			`PCTL_OFS_ROUTE_HI: next_rdata = pin_vec_route[15:8];
			`PCTL_OFS_PEND: next_rdata = {1'b0, pending};
			`PCTL_OFS_SENS_HI: next_rdata = {2'h0, ext_irq_sensitivity_control[13:8]};
			default: next_rdata = 8'h00;
		endcase
	end

	// read data stand one cycle after the strobe, zero otherwise
	always @(posedge clk_sys) begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= next_rdata;
		else
			reg_rdata <= 8'h00;
	end

endmodule

/* File: tb/pctl_board.sv */
// board model that drives the port pins
`timescale 1ns/10ps
module pctl_board (
	// clock
	input wire clk_sys,
	// pad side of the port
	input wire [7:0] pad_out,
	input wire [7:0] pad_oe_n,
	input wire [7:0] pad_pullup,
	// board drivers
	input wire [7:0] ext_en,
	input wire [7:0] ext_val,
	output logic [7:0] pad_in
);
	logic flip = 1'b0;
	// a floating pin wanders so a stale level never reads back
	always @(posedge clk_sys) flip <= ~flip;
	// wire level: port drive, board drive, pull-up, else float
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pad_in[i] = !pad_oe_n[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : pad_pullup[i] | flip;
		end
	end
endmodule

/* File: tb/pctl_port_props.sv */
// assertions on the port block pins
`timescale 1ns/10ps
module pctl_port_props (
	// clock and reset
	input wire clk_sys,
	input wire rst_n,
	// register port
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	// requests and alternates
	input wire [6:0] ext_irq_req,
	input wire [7:0] alt_out_en,
	input wire [7:0] alt_out_val,
	input wire [7:0] alt_in,
	// pads
	input wire [7:0] pad_in,
	input wire [7:0] pad_out,
	input wire [7:0] pad_oe_n,
	input wire [7:0] pad_pullup
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// direction write, then its readback
	sequence s_dwr; reg_wr && reg_addr == 4'h1; endsequence
	sequence s_drd; reg_rd && reg_addr == 4'h1; endsequence
	property p_rw; s_dwr ##1 s_drd |=> reg_rdata == $past(reg_wdata, 2); endproperty
	a_rw: assert property (p_rw) else $error("readback wrong");
	property p_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("rdata not idle");
	property p_ovr; ((pad_oe_n | (pad_out ^ alt_out_val)) & alt_out_en) == 8'h00; endproperty
	a_ovr: assert property (p_ovr) else $error("alternate not driven");
	// synchronised levels lag the pads by two edges
	property p_sync; $past(rst_n) && $past(rst_n, 2) |-> alt_in == $past(pad_in, 2); endproperty
	a_sync: assert property (p_sync) else $error("sync lag wrong");
	property p_doe; s_dwr |=> (~pad_oe_n & ~alt_out_en & ~$past(reg_wdata)) == 8'h00; endproperty
	a_doe: assert property (p_doe) else $error("input pin driven");
	property p_drv;
		reg_wr && reg_addr == 4'h0 |=> ((pad_out ^ $past(reg_wdata)) & ~pad_oe_n & ~alt_out_en) == 8'h00;
	endproperty
	a_drv: assert property (p_drv) else $error("driven value wrong");
	property p_pull; (pad_pullup & ~pad_oe_n & ~alt_out_en) == 8'h00; endproperty
	a_pull: assert property (p_pull) else $error("pull-up on output");
	property p_rst; $rose(rst_n) |-> ext_irq_req == 7'h00 && pad_oe_n == ~alt_out_en; endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind pctl_port pctl_port_props pctl_port_props_inst (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.ext_irq_req(ext_irq_req),
	.alt_out_en(alt_out_en),
	.alt_out_val(alt_out_val),
	.alt_in(alt_in),
	.pad_in(pad_in),
	.pad_out(pad_out),
	.pad_oe_n(pad_oe_n),
	.pad_pullup(pad_pullup)
);

/* File: tb/tb_top.sv */
// self-checking bench for the port block
`timescale 1ns/10ps
module tb_top;
	logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, vec_fetch = 1'b0;
	logic [2:0] vec_fetch_idx = 3'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, alt_out_en = 8'h00, alt_out_val = 8'h00;
	logic [7:0] ext_en = 8'hff, ext_val = 8'h00;
	wire [7:0] reg_rdata, alt_in, pad_in, pad_out, pad_oe_n, pad_pullup;
	wire [6:0] ext_irq_req;
	int error_cnt = 0, comparisons = 0, cyc = 0;
	always #4 clk_sys = ~clk_sys;
	pctl_port pctl_port_inst (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.vec_fetch(vec_fetch),
		.vec_fetch_idx(vec_fetch_idx),
		.ext_irq_req(ext_irq_req),
		.alt_out_en(alt_out_en),
		.alt_out_val(alt_out_val),
		.alt_in(alt_in),
		.pad_in(pad_in),
		.pad_out(pad_out),
		.pad_oe_n(pad_oe_n),
		.pad_pullup(pad_pullup)
	);
	pctl_board pctl_board_inst (
		.clk_sys(clk_sys),
		.pad_out(pad_out),
		.pad_oe_n(pad_oe_n),
		.pad_pullup(pad_pullup),
		.ext_en(ext_en),
		.ext_val(ext_val),
		.pad_in(pad_in)
	);
	task chk(string n, logic [7:0] s, logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	// one bus cycle; each signal set once, right after an edge
	task bus(logic w, logic r, logic [3:0] a, logic [7:0] d);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
	endtask
	// whole-byte writes only, never a bit set or clear
	task wr(logic [3:0] a, logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
		bus(1'b0, 1'b0, a, d);
	endtask
	// read data stands only in the cycle after the strobe
	task rd(logic [3:0] a, logic [7:0] e);
		bus(1'b0, 1'b1, a, 8'h00);
		bus(1'b0, 1'b0, a, 8'h00);
		chk("rdata", reg_rdata, e);
	endtask
	// wait a few edges for the request pattern, then judge it
	task wait_req(logic [7:0] e);
		for (int i = 0; i < 8 && {1'b0, ext_irq_req} !== e; i++) begin
			@(posedge clk_sys);
		end
		chk("req", {1'b0, ext_irq_req}, e);
	endtask
	task t_reset;
		rd(4'h0, 8'h00);
		rd(4'h1, 8'h00);
		rd(4'h2, 8'h00);
		rd(4'h6, 8'h00);
		chk("oe", pad_oe_n, 8'hff);
		$display("reset test done");
	endtask
	task t_inout;
		ext_val <= 8'ha5;
		wr(4'h0, 8'h3c);
		rd(4'h0, 8'ha5);
		ext_en <= 8'h0f;
		bus(1'b1, 1'b0, 4'h1, 8'hf0);
		rd(4'h1, 8'hf0);
		rd(4'h0, 8'h35);
		chk("oe", pad_oe_n, 8'h0f);
		chk("out", pad_out & 8'hf0, 8'h30);
		wr(4'h2, 8'hf0);
		wr(4'h0, 8'h5a);
		chk("oe", pad_oe_n, 8'h5f);
		chk("out", pad_out & ~pad_oe_n, 8'h00);
		rd(4'h9, 8'h00);
		wr(4'h1, 8'h00);
		wr(4'h2, 8'h00);
		$display("in out test done");
	endtask
	// pin 7 driven by the peripheral with direction zero, pins 0..6 by the board;
	// the data read and the alternate input both return the pin levels
	task t_alt;
		ext_en <= 8'h7f;
		ext_val <= 8'h25;
		alt_out_en <= 8'h80;
		alt_out_val <= 8'h80;
		repeat (3) @(posedge clk_sys);
		rd(4'h0, 8'ha5);
		chk("oe", pad_oe_n, 8'h7f);
		chk("alt", alt_in, 8'ha5);
		alt_out_en <= 8'h00;
		ext_en <= 8'hff;
		$display("alternate test done");
	endtask
	task t_irq;
		ext_val <= 8'h01;
		wr(4'h2, 8'h01);
		chk("pull", pad_pullup, 8'h01);
		wr(4'h4, 8'h01);
		wr(4'h3, 8'h02);
		ext_val <= 8'h00;
		wait_req(8'h01);
		rd(4'h6, 8'h01);
		vec_fetch <= 1'b1;
		@(posedge clk_sys);
		vec_fetch <= 1'b0;
		@(posedge clk_sys);
		chk("req", {1'b0, ext_irq_req}, 8'h00);
		ext_val <= 8'h01;
		repeat (5) @(posedge clk_sys);
		chk("req", {1'b0, ext_irq_req}, 8'h00);
		ext_val <= 8'h00;
		wait_req(8'h01);
		wr(4'h3, 8'h01);
		chk("req", {1'b0, ext_irq_req}, 8'h00);
		ext_val <= 8'h01;
		wait_req(8'h01);
		wr(4'h7, 8'h00);
		chk("req", {1'b0, ext_irq_req}, 8'h00);
		$display("interrupt test done");
	endtask
	// shared vector masking, level and both-edge modes, an upper vector
	task t_mask;
		ext_val <= 8'h03;
		wr(4'h3, 8'h02);
		wr(4'h4, 8'h05);
		wr(4'h2, 8'h03);
		ext_val <= 8'h01;
		wait_req(8'h01);
		wr(4'h7, 8'h00);
		chk("req", {1'b0, ext_irq_req}, 8'h00);
		ext_val <= 8'h00;
		repeat (5) @(posedge clk_sys);
		chk("req", {1'b0, ext_irq_req}, 8'h00);
		wr(4'h3, 8'h00);
		wait_req(8'h01);
		wr(4'h7, 8'h00);
		chk("req", {1'b0, ext_irq_req}, 8'h01);
		ext_val <= 8'h03;
		repeat (3) @(posedge clk_sys);
		wr(4'h3, 8'h03);
		chk("req", {1'b0, ext_irq_req}, 8'h00);
		ext_val <= 8'h02;
		wait_req(8'h01);
		vec_fetch <= 1'b1;
		@(posedge clk_sys);
		vec_fetch <= 1'b0;
		ext_val <= 8'h03;
		wait_req(8'h01);
		wr(4'h7, 8'h00);
		ext_val <= 8'h13;
		repeat (3) @(posedge clk_sys);
		wr(4'h5, 8'h02);
		wr(4'h2, 8'h10);
		wr(4'h8, 8'h02);
		rd(4'h8, 8'h02);
		ext_val <= 8'h03;
		wait_req(8'h10);
		vec_fetch_idx <= 3'h4;
		vec_fetch <= 1'b1;
		@(posedge clk_sys);
		vec_fetch <= 1'b0;
		@(posedge clk_sys);
		chk("req", {1'b0, ext_irq_req}, 8'h00);
		wr(4'h2, 8'h00);
		$display("mask test done");
	endtask
	task end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		t_reset;
		t_inout;
		t_alt;
		t_irq;
		t_mask;
		end_sim;
	end
	// cut a hang short
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			end_sim;
		end
	end
endmodule
